// File: src/logical_and_pkg.sv
package logical_and_pkg;

	// ------------------------------------------------------------
	// Opcodes and masks
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_AND_IMM = 8'h54;
	localparam logic [7:0] OPC_AND_DIR = 8'h55;
	localparam logic [7:0] OPC_AND_IND = 8'h56;
	localparam logic [7:0] MASK_AND_IND = 8'hFE;
	localparam logic [7:0] OPC_AND_REG = 8'h58;
	localparam logic [7:0] MASK_AND_REG = 8'hF8;
	localparam logic [7:0] OPC_AND_BIT = 8'h82;
	localparam logic [7:0] OPC_AND_NBIT = 8'hB0;
	localparam logic [7:0] OPC_AND_MEMIMM = 8'h53;

	// ------------------------------------------------------------
	// Instruction lengths in bytes and cycles
	// ------------------------------------------------------------
	localparam logic [15:0] LEN_ONE = 16'h0001;
	localparam logic [15:0] LEN_TWO = 16'h0002;
	localparam logic [15:0] LEN_THREE = 16'h0003;
	localparam int CYC_SHORT = 1;
	localparam int CYC_LONG = 2;

	// ------------------------------------------------------------
	// Memory layout and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic CARRY_RESET = 1'b0;
	localparam logic [15:0] PC_RESET = 16'h0000;

	typedef enum logic [2:0] {
		KIND_NONE = 3'h0,
		KIND_IMM = 3'h1,
		KIND_IND = 3'h2,
		KIND_REG = 3'h3,
		KIND_DIR = 3'h4,
		KIND_BIT = 3'h5,
		KIND_NBIT = 3'h6,
		KIND_MEMIMM = 3'h7
	} and_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC2 = 2'b10
	} exec_state_t;

endpackage

// File: src/logical_and_alu.sv
`timescale 1ns/1ps
module logical_and_alu
	import logical_and_pkg::*;
(
	input wire logical_and_pkg::and_kind_t kind_in,
	input wire logic [7:0] acc_in,
	input wire logic [7:0] src_in,
	input wire logic [7:0] imm_in,
	input wire logic carry_in,
	input wire logic bit_in,
	output logic [7:0] byte_out,
	output logic carry_out
);
	import logical_and_pkg::*;

	always_comb begin
		byte_out = acc_in & src_in;
		carry_out = carry_in;
		case (kind_in)
			KIND_MEMIMM: begin
				byte_out = src_in & imm_in;
			end
			KIND_BIT: begin
				carry_out = carry_in & bit_in;
			end
			KIND_NBIT: begin
				carry_out = carry_in & ~bit_in;
			end
			default: begin
				byte_out = acc_in & src_in;
			end
		endcase
	end
endmodule // logical_and_alu

// File: src/logical_and_instruction_unit.sv
// Function
// - Opcode 54h with immediate byte ANDs it into accumulator; two bytes, one cycle.
// - Opcode 56h/57h ANDs byte pointed to by pointer register 0/1 into accumulator.
// - Opcodes 58h-5Fh AND working register 0-7 into accumulator, one byte, one cycle.
// - Opcode 55h with direct address ANDs that data byte into accumulator.
// - Opcode 82h with bit address sets carry to carry AND that bit.
// - Opcode B0h with bit address sets carry to carry AND NOT bit; two cycles.
// - The inverted-bit form never modifies the addressed source bit.
// - Opcode 53h, address, immediate: AND immediate into memory byte; two cycles.
`timescale 1ns/1ps
module logical_and_instruction_unit
	import logical_and_pkg::*;
#(
	parameter int MEM_DEPTH = 256
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic instr_valid_in,
	input wire logic [7:0] opcode_in,
	input wire logic [7:0] operand1_in,
	input wire logic [7:0] operand2_in,
	input wire logic [15:0] pc_in,
	input wire logic mem_wr_in,
	input wire logic [7:0] mem_addr_in,
	input wire logic [7:0] mem_data_in,
	input wire logic acc_load_in,
	input wire logic [7:0] acc_data_in,
	input wire logic carry_load_in,
	input wire logic carry_data_in,
	output logic ready_out,
	output logic done_out,
	output logic illegal_out,
	output logic [7:0] acc_out,
	output logic carry_out,
	output logic [15:0] pc_out,
	output logic [7:0] mem_rd_data_out
);
	import logical_and_pkg::*;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic and_kind_t decode_kind(input logic [7:0] opc);
		and_kind_t k;
		k = KIND_NONE;
		if (opc == OPC_AND_IMM) k = KIND_IMM;
		else if (opc == OPC_AND_DIR) k = KIND_DIR;
		else if ((opc & MASK_AND_IND) == OPC_AND_IND) k = KIND_IND;
		else if ((opc & MASK_AND_REG) == OPC_AND_REG) k = KIND_REG;
		else if (opc == OPC_AND_BIT) k = KIND_BIT;
		else if (opc == OPC_AND_NBIT) k = KIND_NBIT;
		else if (opc == OPC_AND_MEMIMM) k = KIND_MEMIMM;
		return k;
	endfunction

	function automatic logic [15:0] instr_length(input and_kind_t k);
		logic [15:0] n;
		n = LEN_TWO;
		if (k == KIND_IND || k == KIND_REG) n = LEN_ONE;
		else if (k == KIND_MEMIMM) n = LEN_THREE;
		return n;
	endfunction

	// Low bit addresses fall in the bit area; high ones pick bits of the byte at the 8-aligned address.
	function automatic logic [7:0] bit_byte_addr(input logic [7:0] bit_addr);
		return bit_addr[7] ? {bit_addr[7:3], 3'h0} : (BIT_AREA_BASE + {4'h0, bit_addr[6:3]});
	endfunction

	// ------------------------------------------------------------
	// Internal data memory; working and pointer registers are bytes 0 to 7
	// ------------------------------------------------------------
	logic [7:0] mem [MEM_DEPTH];
	logic next_mem_we;
	logic [7:0] next_mem_addr;
	logic [7:0] next_mem_data;

	and_kind_t kind;
	logic [7:0] src_byte;
	logic bit_val;
	logic [7:0] alu_byte;
	logic alu_carry;

	always_comb begin
		kind = decode_kind(opcode_in);
		bit_val = mem[bit_byte_addr(operand1_in)][operand1_in[2:0]];
		case (kind)
			KIND_IMM: begin
				src_byte = operand1_in;
			end
			KIND_IND: begin
				src_byte = mem[mem[{7'h00, opcode_in[0]}]];
			end
			KIND_REG: begin
				src_byte = mem[{5'h00, opcode_in[2:0]}];
			end
			KIND_DIR, KIND_MEMIMM: begin
				src_byte = mem[operand1_in];
			end
			default: begin
				src_byte = 8'hFF;
			end
		endcase
	end

	logical_and_alu u_alu (
		.kind_in(kind),
		.acc_in(acc_out),
		.src_in(src_byte),
		.imm_in(operand2_in),
		.carry_in(carry_out),
		.bit_in(bit_val),
		.byte_out(alu_byte),
		.carry_out(alu_carry)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	exec_state_t state;
	exec_state_t next_state;
	logic [7:0] pend_byte;
	logic [7:0] pend_addr;
	logic pend_carry;
	logic pend_is_mem;
	logic [7:0] next_pend_byte;
	logic [7:0] next_pend_addr;
	logic next_pend_carry;
	logic next_pend_is_mem;
	logic next_ready;
	logic next_done;
	logic next_illegal;
	logic [7:0] next_acc;
	logic next_carry;
	logic [15:0] next_pc;
	logic accept;

	always_comb begin
		accept = instr_valid_in && ready_out && (kind != KIND_NONE);
		next_state = state;
		next_pend_byte = pend_byte;
		next_pend_addr = pend_addr;
		next_pend_carry = pend_carry;
		next_pend_is_mem = pend_is_mem;
		next_done = 1'b0;
		next_illegal = instr_valid_in && ready_out && (kind == KIND_NONE);
		next_acc = acc_load_in ? acc_data_in : acc_out;
		next_carry = carry_load_in ? carry_data_in : carry_out;
		next_pc = pc_out;
		next_mem_we = mem_wr_in;
		next_mem_addr = mem_addr_in;
		next_mem_data = mem_data_in;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_pc = pc_in + instr_length(kind);
					if (kind == KIND_NBIT || kind == KIND_MEMIMM) begin
						// The result is caught now so that a late side write cannot alter it.
						next_state = ST_EXEC2;
						next_pend_byte = alu_byte;
						next_pend_addr = operand1_in;
						next_pend_carry = alu_carry;
						next_pend_is_mem = (kind == KIND_MEMIMM);
					end else if (kind == KIND_BIT) begin
						next_carry = alu_carry;
						next_done = 1'b1;
					end else begin
						next_acc = alu_byte;
						next_done = 1'b1;
					end
				end
			end
			ST_EXEC2: begin
				next_state = ST_IDLE;
				next_done = 1'b1;
				if (pend_is_mem) begin
					next_mem_we = 1'b1;
					next_mem_addr = pend_addr;
					next_mem_data = pend_byte;
				end else begin
					next_carry = pend_carry;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_ready = (next_state == ST_IDLE);
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			state <= ST_IDLE;
			pend_byte <= 8'h00;
			pend_addr <= 8'h00;
			pend_carry <= 1'b0;
			pend_is_mem <= 1'b0;
			ready_out <= 1'b0;
			done_out <= 1'b0;
			illegal_out <= 1'b0;
			acc_out <= ACC_RESET;
			carry_out <= CARRY_RESET;
			pc_out <= PC_RESET;
			mem_rd_data_out <= 8'h00;
		end else begin
			state <= next_state;
			pend_byte <= next_pend_byte;
			pend_addr <= next_pend_addr;
			pend_carry <= next_pend_carry;
			pend_is_mem <= next_pend_is_mem;
			ready_out <= next_ready;
			done_out <= next_done;
			illegal_out <= next_illegal;
			acc_out <= next_acc;
			carry_out <= next_carry;
			pc_out <= next_pc;
			mem_rd_data_out <= mem[mem_addr_in];
		end
	end

	// Memory holds data only, so it is left out of reset.
	always_ff @(posedge mclk_in) begin
		if (next_mem_we && !sys_rst_in) begin
			mem[next_mem_addr] <= next_mem_data;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_IMM_RESULT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(accept && opcode_in == OPC_AND_IMM && !acc_load_in) |=> (acc_out == ($past(acc_out) & $past(operand1_in))) && done_out)
		else $error("immediate AND result wrong");
	AST_IND_RESULT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(accept && kind == KIND_IND && !acc_load_in)
		|=> acc_out == ($past(acc_out) & $past(mem[mem[{7'h00, opcode_in[0]}]])))
		else $error("indirect AND result wrong");
	AST_REG_ONE_CYCLE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(accept && kind == KIND_REG) |=> done_out && ready_out && pc_out == $past(pc_in) + LEN_ONE)
		else $error("register AND not done in one cycle");
	AST_DIR_RESULT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(accept && kind == KIND_DIR && !acc_load_in) |=> acc_out == ($past(acc_out) & $past(mem[operand1_in])))
		else $error("direct AND result wrong");
	AST_BIT_CARRY: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(accept && kind == KIND_BIT && !carry_load_in) |=> carry_out == ($past(carry_out) & $past(bit_val)))
		else $error("bit AND carry wrong");
	AST_NBIT_TWO_CYCLES: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(accept && kind == KIND_NBIT) |=> !done_out && !ready_out ##1 done_out && ready_out)
		else $error("inverted bit AND timing wrong");
	AST_NBIT_NO_WRITE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(accept && kind == KIND_NBIT && !mem_wr_in) ##1 !mem_wr_in
		|=> mem[bit_byte_addr(pend_addr)] == $past(mem[bit_byte_addr(pend_addr)]))
		else $error("inverted bit AND wrote memory");
	AST_MEMIMM_WRITE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(accept && kind == KIND_MEMIMM) |=> next_mem_we && next_mem_addr == $past(operand1_in, 1)
		&& next_mem_data == ($past(mem[operand1_in]) & $past(operand2_in)))
		else $error("memory AND write wrong");
	AST_PC_ADVANCE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(accept && kind == KIND_MEMIMM) |=> pc_out == $past(pc_in) + LEN_THREE)
		else $error("program counter not advanced by three");

endmodule // logical_and_instruction_unit

// File: verification/fetch_model.sv
`timescale 1ns/1ps
// Stands in for the fetch stage that offers instruction bytes to the unit.
module fetch_model (
	input wire logic clk_in,
	input wire logic ready_in,
	output logic valid_out,
	output logic [7:0] op_out,
	output logic [7:0] b1_out,
	output logic [7:0] b2_out,
	output logic [15:0] pc_out,
	output logic taken_out
);
	initial begin
		valid_out = 1'b0;
		op_out = 8'h00;
		b1_out = 8'h00;
		b2_out = 8'h00;
		pc_out = 16'h0000;
		taken_out = 1'b0;
	end

	// Called at a falling edge; holds the bytes until a rising edge with ready high takes them, or releases them after 20 falling edges.
	task automatic issue(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2, input logic [15:0] pc);
		int n;
		taken_out = 1'b0;
		valid_out = 1'b1;
		op_out = op;
		b1_out = b1;
		b2_out = b2;
		pc_out = pc;
		for (n = 0; n < 20 && taken_out == 1'b0; n++) begin
			if (ready_in === 1'b1) taken_out = 1'b1;
			@(negedge clk_in);
		end
		// Released bytes are inverted so a stale value can never pass for a fresh one.
		valid_out = 1'b0;
		op_out = ~op;
		b1_out = ~b1;
		b2_out = ~b2;
		pc_out = ~pc;
	endtask
endmodule // fetch_model

// File: verification/logical_and_instruction_unit_tb.sv
`timescale 1ns/1ps
module logical_and_instruction_unit_tb;
	import logical_and_pkg::*;
	logic mclk_in, sys_rst_in, mem_wr_in, acc_load_in, carry_load_in, carry_data_in;
	logic [7:0] mem_addr_in, mem_data_in, acc_data_in;
	logic valid, taken, ready_out, done_out, illegal_out, carry_out;
	logic [7:0] op, b1, b2, acc_out, mem_rd_data_out;
	logic [15:0] fpc, pc_out, pc;
	int n_fail, compares, r;

	logical_and_instruction_unit DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .instr_valid_in(valid),
		.opcode_in(op), .operand1_in(b1), .operand2_in(b2), .pc_in(fpc), .mem_wr_in(mem_wr_in),
		.mem_addr_in(mem_addr_in), .mem_data_in(mem_data_in), .acc_load_in(acc_load_in),
		.acc_data_in(acc_data_in), .carry_load_in(carry_load_in), .carry_data_in(carry_data_in),
		.ready_out(ready_out), .done_out(done_out), .illegal_out(illegal_out), .acc_out(acc_out),
		.carry_out(carry_out), .pc_out(pc_out), .mem_rd_data_out(mem_rd_data_out));

	fetch_model feed (.clk_in(mclk_in), .ready_in(ready_out), .valid_out(valid), .op_out(op),
		.b1_out(b1), .b2_out(b2), .pc_out(fpc), .taken_out(taken));

	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end

	task automatic stop_test();
		if (n_fail == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wmem(input logic [7:0] a, input logic [7:0] d);
		mem_addr_in = a;
		mem_data_in = d;
		mem_wr_in = 1'b1;
		@(negedge mclk_in);
		mem_wr_in = 1'b0;
	endtask

	task automatic rmem(input logic [7:0] a, input logic [7:0] exp);
		mem_addr_in = a;
		@(negedge mclk_in);
		chk(16'(mem_rd_data_out), 16'(exp));
	endtask

	task automatic setac(input logic [7:0] a, input logic c);
		acc_data_in = a;
		carry_data_in = c;
		acc_load_in = 1'b1;
		carry_load_in = 1'b1;
		@(negedge mclk_in);
		acc_load_in = 1'b0;
		carry_load_in = 1'b0;
	endtask

	// Returns at the falling edge where the result must be visible.
	task automatic run(input logic [7:0] o, input logic [7:0] x, input logic [7:0] y, input int len, input bit two);
		feed.issue(o, x, y, pc);
		if (taken !== 1'b1) begin
			n_fail++;
			$display("FAIL %0t fetch stage timed out", $time);
			stop_test();
		end
		chk(pc_out, pc + 16'(len));
		chk(16'(done_out), 16'(!two));
		chk(16'(illegal_out), 16'h0000);
		if (two) begin
			chk(16'(ready_out), 16'h0000);
			@(negedge mclk_in);
			chk(16'(done_out), 16'h0001);
		end
		pc = pc + 16'(len);
	endtask

	task automatic t_imm();
		setac(8'hF5, 1'b0);
		run(8'h54, 8'h3C, 8'h00, 2, 0);
		chk(16'(acc_out), 16'h0034);
	endtask

	task automatic t_reg();
		for (r = 0; r < 8; r++) begin
			wmem(8'(r), 8'(8'hA5 ^ (r * 8'h11)));
			setac(8'h3C, 1'b0);
			run(8'(8'h58 + r), 8'h00, 8'h00, 1, 0);
			chk(16'(acc_out), 16'(8'h3C & (8'hA5 ^ (r * 8'h11))));
		end
	endtask

	task automatic t_ind();
		wmem(8'h00, 8'h52);
		wmem(8'h01, 8'h37);
		wmem(8'h52, 8'h0F);
		wmem(8'h37, 8'hF0);
		setac(8'h3F, 1'b0);
		run(8'h56, 8'h00, 8'h00, 1, 0);
		chk(16'(acc_out), 16'h000F);
		setac(8'hF3, 1'b0);
		run(8'h57, 8'h00, 8'h00, 1, 0);
		chk(16'(acc_out), 16'h00F0);
	endtask

	task automatic t_dir();
		wmem(8'hFF, 8'hF0);
		setac(8'h77, 1'b0);
		run(8'h55, 8'hFF, 8'h00, 2, 0);
		chk(16'(acc_out), 16'h0070);
	endtask

	task automatic t_bit();
		wmem(8'h25, 8'h08);
		setac(8'h00, 1'b1);
		run(8'h82, 8'h2B, 8'h00, 2, 0);
		chk(16'(carry_out), 16'h0001);
		wmem(8'h25, 8'hF7);
		setac(8'h00, 1'b1);
		run(8'h82, 8'h2B, 8'h00, 2, 0);
		chk(16'(carry_out), 16'h0000);
	endtask

	task automatic t_nbit();
		wmem(8'h80, 8'h58);
		setac(8'h00, 1'b1);
		run(8'hB0, 8'h85, 8'h00, 2, 1);
		chk(16'(carry_out), 16'h0001);
		setac(8'h00, 1'b1);
		run(8'hB0, 8'h84, 8'h00, 2, 1);
		chk(16'(carry_out), 16'h0000);
		rmem(8'h80, 8'h58);
	endtask

	task automatic t_mimm();
		wmem(8'h57, 8'hA5);
		run(8'h53, 8'h57, 8'h0F, 3, 1);
		rmem(8'h57, 8'h05);
	endtask

	// A foreign opcode is not consumed: the counter stays and only the refusal pulse shows.
	task automatic t_ill();
		feed.issue(8'hE4, 8'h00, 8'h00, pc);
		chk(16'(illegal_out), 16'h0001);
		chk(pc_out, pc);
		chk(16'(done_out), 16'h0000);
		@(negedge mclk_in);
		chk(16'(illegal_out), 16'h0000);
	endtask

	initial begin
		n_fail = 0;
		compares = 0;
		pc = 16'h0100;
		sys_rst_in = 1'b1;
		mem_wr_in = 1'b0;
		acc_load_in = 1'b0;
		carry_load_in = 1'b0;
		carry_data_in = 1'b0;
		mem_addr_in = 8'h00;
		mem_data_in = 8'h00;
		acc_data_in = 8'h00;
		repeat (4) @(negedge mclk_in);
		sys_rst_in = 1'b0;
		@(negedge mclk_in);
		t_imm();
		t_reg();
		t_ind();
		t_dir();
		t_bit();
		t_nbit();
		t_mimm();
		t_ill();
		stop_test();
	end
endmodule // logical_and_instruction_unit_tb
